// ==== logic/qrbsp_port.v ====
// burst static ram host port: command decode, write capture, storage, read launch
// assumes all pins asynchronous to i_mclk; link clocks much slower than i_mclk
//
// How it works
// [R1] every transfer moves four words over two input clock periods
// [R2] both strobes high at input clock rise is a no-operation
// [R3] address and strobes sampled only at true input clock rise
// [R4] write words sampled at true and complementary input clock rises
// [R5] write data bus is 36 bits wide, bits 0 to 35
// [R6] read data bus is 36 bits wide, bits 0 to 35
// [R7] low read strobe registers address and starts a read burst
// [R8] read strobe ignored at the input clock rise after a read
// [R9] low write strobe registers address and starts a write burst
// [R10] write strobe ignored at the input clock rise after a write
// [R11] only lanes with low byte enable are stored
// [R12] byte enables sampled with each write data word
// [R13] four byte enables, one per nine-bit lane
// [R14] read data launched on output clocks, or input clocks if held high
// [R15] first and third read words launched on complementary clock rise
// [R16] second and fourth read words launched on true clock rise
// [R17] host holds output clocks high to select input clock timing
// [R18] read and write bursts may run at the same time
`timescale 1ns/1ps
`include "qrbsp_defs.vh"

module qrbsp_port (
	// clock and reset
	input  wire                       i_mclk,
	input  wire                       i_rst,
	// input clock pair
	input  wire                       i_kclk,
	input  wire                       i_kclk_n,
	// output clock pair
	input  wire                       i_cclk,
	input  wire                       i_cclk_n,
	// command
	input  wire                       i_rd_n,
	input  wire                       i_wr_n,
	input  wire [`QRBSP_ADDR_W-1:0]   i_addr,
	// write data
	input  wire [`QRBSP_DATA_W-1:0]   i_write_data_in,
	input  wire [`QRBSP_LANES-1:0]    i_byte_lane_write_enable_n,
	// read data
	output reg  [`QRBSP_DATA_W-1:0]   o_read_data_out,
	output reg                        o_read_valid,
	output reg                        o_read_overrun
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg  [`QRBSP_PIN_W-1:0]  pin_meta_r;
	reg  [`QRBSP_PIN_W-1:0]  pin_sync_r;
	reg  [3:0]               clk_prev_r;
	wire [`QRBSP_PIN_W-1:0]  pin_raw;

	assign pin_raw = {i_kclk, i_kclk_n, i_cclk, i_cclk_n, i_rd_n, i_wr_n,
		i_addr, i_write_data_in, i_byte_lane_write_enable_n};

	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pin_meta_r <= {`QRBSP_PIN_W{1'b1}};
			pin_sync_r <= {`QRBSP_PIN_W{1'b1}};
			clk_prev_r <= 4'hF;
		end
		else
		begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			clk_prev_r <= pin_sync_r[`QRBSP_P_KCLK:`QRBSP_P_CCLK_N];
		end
	end

	wire                      k_s    = pin_sync_r[`QRBSP_P_KCLK];
	wire                      kn_s   = pin_sync_r[`QRBSP_P_KCLK_N];
	wire                      c_s    = pin_sync_r[`QRBSP_P_CCLK];
	wire                      cn_s   = pin_sync_r[`QRBSP_P_CCLK_N];
	wire                      rd_n_s = pin_sync_r[`QRBSP_P_RD_N];
	wire                      wr_n_s = pin_sync_r[`QRBSP_P_WR_N];
	wire [`QRBSP_ADDR_W-1:0]  addr_s = pin_sync_r[`QRBSP_P_ADDR_HI:`QRBSP_P_ADDR_LO];
	// [R5] 36-bit write word
	wire [`QRBSP_DATA_W-1:0]  data_s = pin_sync_r[`QRBSP_P_DATA_HI:`QRBSP_P_DATA_LO];
	wire [`QRBSP_LANES-1:0]   be_n_s = pin_sync_r[`QRBSP_P_BE_HI:`QRBSP_P_BE_LO];

	// ----------------------------------------
	// clock edge detect
	// ----------------------------------------
	wire k_rise  = k_s  & ~clk_prev_r[3];
	wire kn_rise = kn_s & ~clk_prev_r[2];
	wire c_rise  = c_s  & ~clk_prev_r[1];
	wire cn_rise = cn_s & ~clk_prev_r[0];

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	reg  rd_blk_r;
	reg  wr_blk_r;
	wire rd_acc;
	wire wr_acc;

	// [R3] [R7] [R8] read accept gating
	assign rd_acc = k_rise & ~rd_n_s & ~rd_blk_r;
	// [R3] [R9] [R10] write accept gating
	assign wr_acc = k_rise & ~wr_n_s & ~wr_blk_r;

	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rd_blk_r <= 1'b0;
			wr_blk_r <= 1'b0;
		end
		else if (k_rise)
		begin
			// [R2] strobes high: no-op, address dropped
			rd_blk_r <= rd_acc;
			wr_blk_r <= wr_acc;
		end
	end

	// ----------------------------------------
	// write burst capture
	// ----------------------------------------
	reg  [`QRBSP_ADDR_W-1:0]  wr_naddr_r;
	reg  [`QRBSP_ADDR_W-1:0]  wr_addr_r;
	reg                       wr_wait_r;
	reg                       wr_act_r;
	reg  [`QRBSP_IDX_W-1:0]   wr_idx_r;
	reg                       wr_en;
	reg  [`QRBSP_MEM_AW-1:0]  wr_a;

	// [R1] [R4] word slots: k, k#, k, k# after the command
	always @*
	begin
		wr_en = 1'b0;
		wr_a  = {wr_addr_r, wr_idx_r};
		if (k_rise & wr_wait_r)
		begin
			wr_en = 1'b1;
			wr_a  = {wr_naddr_r, 2'h0};
		end
		else if (k_rise & wr_act_r & (wr_idx_r == 2'h2))
			wr_en = 1'b1;
		else if (kn_rise & wr_act_r & wr_idx_r[0])
			wr_en = 1'b1;
	end

	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_naddr_r <= {`QRBSP_ADDR_W{1'b0}};
			wr_addr_r  <= {`QRBSP_ADDR_W{1'b0}};
			wr_wait_r  <= 1'b0;
			wr_act_r   <= 1'b0;
			wr_idx_r   <= 2'h0;
		end
		else
		begin
			if (k_rise)
			begin
				wr_wait_r <= wr_acc;
				if (wr_acc)
					wr_naddr_r <= addr_s;
			end
			if (k_rise & wr_wait_r)
			begin
				wr_addr_r <= wr_naddr_r;
				wr_act_r  <= 1'b1;
				wr_idx_r  <= 2'h1;
			end
			else if (wr_en)
			begin
				wr_idx_r <= wr_idx_r + 2'h1;
				if (wr_idx_r == 2'h3)
					wr_act_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// storage array
	// ----------------------------------------
	reg [`QRBSP_DATA_W-1:0] mem [0:`QRBSP_MEM_WORDS-1];
	integer                 lane;

	always @(posedge i_mclk)
	begin
		if (wr_en)
		begin
			// [R11] [R12] [R13] per-word lane enables
			for (lane = 0; lane < `QRBSP_LANES; lane = lane + 1)
			begin
				if (!be_n_s[lane])
					mem[wr_a][lane*`QRBSP_LANE_W +: `QRBSP_LANE_W] <=
						data_s[lane*`QRBSP_LANE_W +: `QRBSP_LANE_W];
			end
		end
	end

	// ----------------------------------------
	// read burst fetch
	// ----------------------------------------
	reg  [`QRBSP_ADDR_W-1:0]  rd_paddr_r;
	reg                       rd_pend_r;
	reg  [`QRBSP_ADDR_W-1:0]  rd_base_r;
	reg                       rd_busy_r;
	reg  [`QRBSP_IDX_W-1:0]   rd_idx_r;
	wire                      rd_take;
	wire                      fifo_in_ready;
	wire                      fifo_out_valid;
	wire [`QRBSP_DATA_W-1:0]  fifo_out_data;
	wire [`QRBSP_DATA_W-1:0]  rd_word;
	reg                       pop;

	assign rd_take = rd_pend_r & ~rd_busy_r;
	assign rd_word = mem[{rd_base_r, rd_idx_r}];

	// [R18] fetch runs independent of write capture
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rd_paddr_r     <= {`QRBSP_ADDR_W{1'b0}};
			rd_pend_r      <= 1'b0;
			rd_base_r      <= {`QRBSP_ADDR_W{1'b0}};
			rd_busy_r      <= 1'b0;
			rd_idx_r       <= 2'h0;
			o_read_overrun <= 1'b0;
		end
		else
		begin
			o_read_overrun <= rd_acc & rd_pend_r & ~rd_take;
			if (rd_acc)
			begin
				rd_paddr_r <= addr_s;
				rd_pend_r  <= 1'b1;
			end
			else if (rd_take)
				rd_pend_r <= 1'b0;
			if (rd_take)
			begin
				rd_base_r <= rd_paddr_r;
				rd_busy_r <= 1'b1;
				rd_idx_r  <= 2'h0;
			end
			// [R1] four words pushed per burst
			else if (rd_busy_r & fifo_in_ready)
			begin
				rd_idx_r <= rd_idx_r + 2'h1;
				if (rd_idx_r == 2'h3)
					rd_busy_r <= 1'b0;
			end
		end
	end

	qrbsp_fifo #(
		.WIDTH (`QRBSP_DATA_W),
		.DEPTH (`QRBSP_FIFO_D),
		.AW    (`QRBSP_FIFO_AW)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_in_valid  (rd_busy_r),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (rd_word),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (pop),
		.o_out_data  (fifo_out_data)
	);

	// ----------------------------------------
	// output clock source select
	// ----------------------------------------
	reg [`QRBSP_CHOLD_W-1:0] chold_r;
	reg                      mode_k_r;

	// [R14] [R17] both output clocks held high selects input pair
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			chold_r  <= {`QRBSP_CHOLD_W{1'b0}};
			mode_k_r <= 1'b0;
		end
		else
		begin
			if (!(c_s & cn_s))
				chold_r <= {`QRBSP_CHOLD_W{1'b0}};
			else if (chold_r != `QRBSP_CHOLD_CYC)
				chold_r <= chold_r + 1'b1;
			mode_k_r <= (chold_r == `QRBSP_CHOLD_CYC);
		end
	end

	// ----------------------------------------
	// read launch
	// ----------------------------------------
	reg  phase_r;
	wire odd_edge  = mode_k_r ? kn_rise : cn_rise;
	wire even_edge = mode_k_r ? k_rise  : c_rise;
	wire slot      = phase_r ? even_edge : odd_edge;

	// [R15] [R16] words 1,3 on complementary rise, 2,4 on true rise
	always @*
	begin
		pop = slot & fifo_out_valid;
	end

	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			phase_r         <= 1'b0;
			o_read_data_out <= {`QRBSP_DATA_W{1'b0}};
			o_read_valid    <= 1'b0;
		end
		else if (slot)
		begin
			// [R6] [R14] launch one word per slot
			o_read_valid <= fifo_out_valid;
			if (fifo_out_valid)
			begin
				o_read_data_out <= fifo_out_data;
				phase_r         <= ~phase_r;
			end
		end
	end

endmodule

// ==== logic/qrbsp_defs.vh ====
// shared constants of the quad rate burst sram port
// assumes inclusion by bare name from the design files
`ifndef QRBSP_DEFS_VH
`define QRBSP_DEFS_VH

// ----------------------------------------
// organisation (x36)
// ----------------------------------------
`define QRBSP_DATA_W     36
`define QRBSP_LANES      4
`define QRBSP_LANE_W     9
`define QRBSP_ADDR_W     6
`define QRBSP_BURST      4
`define QRBSP_IDX_W      2
`define QRBSP_MEM_AW     8
`define QRBSP_MEM_WORDS  256

// ----------------------------------------
// pin bundle layout for synchronisers
// ----------------------------------------
`define QRBSP_PIN_W      52
`define QRBSP_P_KCLK     51
`define QRBSP_P_KCLK_N   50
`define QRBSP_P_CCLK     49
`define QRBSP_P_CCLK_N   48
`define QRBSP_P_RD_N     47
`define QRBSP_P_WR_N     46
`define QRBSP_P_ADDR_HI  45
`define QRBSP_P_ADDR_LO  40
`define QRBSP_P_DATA_HI  39
`define QRBSP_P_DATA_LO  4
`define QRBSP_P_BE_HI    3
`define QRBSP_P_BE_LO    0

// ----------------------------------------
// read data buffer
// ----------------------------------------
`define QRBSP_FIFO_D     16
`define QRBSP_FIFO_AW    4

// ----------------------------------------
// timing
// ----------------------------------------
`define QRBSP_MCLK_NS    5
`define QRBSP_CHOLD_NS   40
`define QRBSP_CHOLD_CYC  (`QRBSP_CHOLD_NS / `QRBSP_MCLK_NS)
`define QRBSP_CHOLD_W    4

`endif

// ==== logic/qrbsp_fifo.v ====
// synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps

module qrbsp_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             i_mclk,
	input  wire             i_rst,
	// fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_r;
	reg [AW-1:0]    rptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	assign o_in_ready  = (count_r != DEPTH[AW:0]);
	assign o_out_valid = (count_r != {(AW+1){1'b0}});
	assign o_out_data  = mem[rptr_r];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// ----------------------------------------
	// pointers and fill level
	// ----------------------------------------
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wptr_r  <= {AW{1'b0}};
			rptr_r  <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (pop)
				rptr_r <= rptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always @(posedge i_mclk)
	begin
		if (push)
			mem[wptr_r] <= i_in_data;
	end

endmodule

// ==== verif/qrbsp_port_properties.sv ====
// checker for the read side of the burst sram port
// assumes clock pins toggle far slower than i_mclk
`timescale 1ns/1ps
`include "qrbsp_defs.vh"

module qrbsp_port_properties (
	// clock, reset, clock pairs
	input wire                     i_mclk,
	input wire                     i_rst,
	input wire                     i_kclk,
	input wire                     i_kclk_n,
	input wire                     i_cclk,
	input wire                     i_cclk_n,
	// command and read data
	input wire                     i_rd_n,
	input wire [`QRBSP_DATA_W-1:0] o_read_data_out,
	input wire                     o_read_valid
);
	reg  [3:0] p_r;
	reg  [3:0] se_r;
	reg  [7:0] due_r;
	reg        acc_r;
	reg        any_r;
	reg        comp_r;
	reg        wi_r;
	wire       cup  = i_cclk & i_cclk_n;
	wire       kr   = i_kclk & !p_r[3];
	wire       nrs  = (i_cclk_n & !p_r[0]) | (cup & i_kclk_n & !p_r[2]);
	wire       slot = nrs | (i_cclk & !p_r[1]) | (cup & kr);
	wire       take = kr & !i_rd_n & !acc_r;
	wire       pop  = (se_r == 4'h6) & o_read_valid;

	// slot age, slot kind, words still owed
	always @(posedge i_mclk or posedge i_rst)
		if (i_rst)
		begin
			p_r    <= 4'hF;
			se_r   <= 4'hF;
			due_r  <= 8'h00;
			acc_r  <= 1'b0;
			any_r  <= 1'b0;
			comp_r <= 1'b0;
			wi_r   <= 1'b0;
		end
		else
		begin
			p_r    <= {i_kclk, i_kclk_n, i_cclk, i_cclk_n};
			se_r   <= slot ? 4'h0 : se_r + {3'h0, se_r != 4'hF};
			comp_r <= slot ? nrs : comp_r;
			acc_r  <= kr ? take : acc_r;
			any_r  <= any_r | take;
			wi_r   <= wi_r ^ pop;
			due_r  <= due_r + (take ? 8'h04 : 8'h00) - {7'h00, pop};
		end

	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_data_slot:
		assert property ($changed(o_read_data_out) |-> se_r inside {[1:7]})
		else $error("data moved off slot");
	a_valid_slot:
		assert property ($changed(o_read_valid) |-> se_r inside {[1:7]})
		else $error("valid moved off slot");
	a_data_holds:
		assert property ($fell(o_read_valid) |-> $stable(o_read_data_out))
		else $error("data changed without word");
	a_burst_count:
		assert property (pop |-> due_r != 8'h00)
		else $error("more words than bursts");
	a_nop_silent:
		assert property (!any_r |-> !o_read_valid)
		else $error("word without read");
	a_odd_word:
		assert property (pop && !wi_r |-> comp_r)
		else $error("odd word on true edge");
	a_even_word:
		assert property (pop && wi_r |-> !comp_r)
		else $error("even word on comp edge");
	a_reset_quiet:
		assert property ($fell(i_rst) |-> !o_read_valid ##1 !o_read_valid)
		else $error("word right after reset");
endmodule

// ==== verif/qrbsp_host.sv ====
// host controller model: clock pairs, strobes, four word bursts
// assumes i_mclk at 200 MHz, one input clock period is 25 cycles
`timescale 1ns/1ps

module qrbsp_host (
	// clock and mode
	input  wire        i_mclk,
	input  wire        i_use_c,
	// clock pairs
	output wire        o_kclk,
	output wire        o_kclk_n,
	output wire        o_cclk,
	output wire        o_cclk_n,
	// command and write data
	output reg         o_rd_n = 1'b1,
	output reg         o_wr_n = 1'b1,
	output reg  [5:0]  o_addr = 6'h00,
	output reg  [35:0] o_data = 36'h0,
	output reg  [3:0]  o_be_n = 4'hF
);
	reg [4:0] cnt = 5'h00;

	assign o_kclk   = cnt < 5'h0C;
	assign o_kclk_n = !o_kclk;
	// pair held high picks input clock timing
	assign o_cclk   = i_use_c ? o_kclk_n : 1'b1;
	assign o_cclk_n = i_use_c ? o_kclk : 1'b1;

	always @(posedge i_mclk)
		cnt <= (cnt == 5'h18) ? 5'h00 : cnt + 5'h01;

	task at(input [4:0] p);
	begin
		@(posedge i_mclk);
		while (cnt != p)
			@(posedge i_mclk);
	end
	endtask

	// command, then four words with enables
	task xfer(input rd, input wr, input rep, input [5:0] a, input [143:0] d,
		input [15:0] be);
	integer i;
	begin
		at(5'h12);
		o_rd_n <= !rd;
		o_wr_n <= !wr;
		o_addr <= a;
		for (i = 0; i < 4; i = i + 1)
		begin
			at(i[0] ? 5'h06 : 5'h12);
			o_data <= d[i*36 +: 36];
			o_be_n <= be[i*4 +: 4];
			if (i == 0)
			begin
				o_rd_n <= !(rd & rep);
				o_wr_n <= !(wr & rep);
				o_addr <= a + 6'h01;
			end
			if (i == 1)
				{o_rd_n, o_wr_n} <= 2'h3;
		end
		// released lines show the inverse of their last value
		at(5'h12);
		o_data <= ~o_data;
		o_be_n <= ~o_be_n;
	end
	endtask
endmodule

// ==== verif/tb_top.sv ====
// testbench: host model drives the port, read words checked per slot
// assumes the checker bound below
`timescale 1ns/1ps

module tb_top;
	reg         i_mclk = 1'b0;
	reg         i_rst = 1'b1;
	reg         use_c = 1'b0;
	wire        kc, kn, cc, cn, rd_n, wr_n, rv, ovr;
	wire [5:0]  ad;
	wire [3:0]  be_n;
	wire [35:0] wd, rdat;
	reg  [35:0] m [0:255];
	reg  [35:0] q [$];
	reg         ph [$];
	integer     err_count = 0;
	integer     total_checks = 0;
	integer     cyc = 0;

	qrbsp_host qrbsp_host_inst (.i_mclk(i_mclk), .i_use_c(use_c), .o_kclk(kc),
		.o_kclk_n(kn), .o_cclk(cc), .o_cclk_n(cn), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_addr(ad), .o_data(wd), .o_be_n(be_n));
	qrbsp_port qrbsp_port_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_kclk(kc),
		.i_kclk_n(kn), .i_cclk(cc), .i_cclk_n(cn), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_addr(ad), .i_write_data_in(wd), .i_byte_lane_write_enable_n(be_n),
		.o_read_data_out(rdat), .o_read_valid(rv), .o_read_overrun(ovr));

	initial
		forever #2.5 i_mclk = ~i_mclk;

	task cmp(input [35:0] got, input [35:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	task finish_test;
	begin
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// words sampled mid slot, with the slot kind
	always @(posedge i_mclk)
	begin
		cyc = cyc + 1;
		if (rv === 1'b1 && qrbsp_host_inst.cnt inside {5'h06, 5'h12})
		begin
			q.push_back(rdat);
			ph.push_back(qrbsp_host_inst.cnt == 5'h12);
		end
		if (ovr !== 1'b0)
			cmp(ovr, 36'h0);
		if (cyc == 8000)
		begin
			err_count = err_count + 1;
			finish_test;
		end
	end

	task op(input rd, input w, input rep, input [5:0] a, input [143:0] d,
		input [15:0] be);
	integer i, l;
	begin
		for (i = 0; i < 4; i = i + 1)
			for (l = 0; l < 4; l = l + 1)
				if (w && !be[i*4+l])
					m[{a, i[1:0]}][l*9 +: 9] = d[i*36+l*9 +: 9];
		qrbsp_host_inst.xfer(rd, w, rep, a, d, be);
	end
	endtask

	task rdchk(input [5:0] a);
	integer i;
	begin
		i = 0;
		while (q.size() < 4 && i < 300)
		begin
			@(posedge i_mclk);
			i = i + 1;
		end
		repeat (60) @(posedge i_mclk);
		cmp(q.size(), 36'h4);
		for (i = 0; i < 4 && i < q.size(); i = i + 1)
		begin
			cmp(q[i], m[{a, i[1:0]}]);
			cmp(ph[i], !i[0] ^ use_c);
		end
		q.delete();
		ph.delete();
	end
	endtask

	task t_basic;
	begin
		repeat (75) @(posedge i_mclk);
		cmp(q.size(), 36'h0);
		op(0, 1, 0, 6'h05, 144'h0123456789ABCDEF0123456789ABCDEF0123, 16'h0000);
		op(1, 0, 0, 6'h05, 144'h0, 16'hFFFF);
		rdchk(6'h05);
		$display("basic done");
	end
	endtask

	task t_lanes;
	begin
		op(0, 1, 0, 6'h05, 144'hFEDCBA9876543210FEDCBA9876543210FEDC, 16'h5A3C);
		op(1, 0, 0, 6'h05, 144'h0, 16'hFFFF);
		rdchk(6'h05);
		$display("lanes done");
	end
	endtask

	task t_both;
	begin
		qrbsp_host_inst.xfer(1, 1, 0, 6'h05, 144'h00112233445566778899AABBCCDDEEFF0011, 16'h0000);
		rdchk(6'h05);
		op(1, 1, 0, 6'h05, 144'h00112233445566778899AABBCCDDEEFF0011, 16'h0000);
		rdchk(6'h05);
		$display("both done");
	end
	endtask

	task t_repeat;
	begin
		op(0, 1, 0, 6'h08, 144'hFEDCBA9876543210FEDCBA9876543210FEDC, 16'h0000);
		op(0, 1, 0, 6'h07, 144'hFEDCBA9876543210FEDCBA9876543210FEDC, 16'h0000);
		op(0, 1, 1, 6'h07, 144'h0123456789ABCDEF0123456789ABCDEF0123, 16'h1248);
		op(1, 0, 1, 6'h08, 144'h0, 16'hFFFF);
		rdchk(6'h08);
		op(1, 0, 0, 6'h07, 144'h0, 16'hFFFF);
		rdchk(6'h07);
		$display("repeat done");
	end
	endtask

	task t_cmode;
	begin
		use_c <= 1'b1;
		repeat (50) @(posedge i_mclk);
		op(1, 0, 0, 6'h05, 144'h0, 16'hFFFF);
		rdchk(6'h05);
		use_c <= 1'b0;
		repeat (50) @(posedge i_mclk);
		$display("output clock done");
	end
	endtask

	initial
	begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_basic;
		t_lanes;
		t_both;
		t_repeat;
		t_cmode;
		finish_test;
	end
endmodule

bind qrbsp_port qrbsp_port_properties qrbsp_port_properties_inst (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_kclk(i_kclk), .i_kclk_n(i_kclk_n), .i_cclk(i_cclk),
	.i_cclk_n(i_cclk_n), .i_rd_n(i_rd_n), .o_read_data_out(o_read_data_out),
	.o_read_valid(o_read_valid));
